//--- rtl/tje_arith.sv
// add or subtract of two words with end borrow out
// pure combinational, used for both the main sum and the zero test
`timescale 1ns/1ps
`default_nettype none
module tje_arith #(
  parameter int W = 72
) (
  // operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic sub_i,
  // result
  output logic [W-1:0] sum_o,
  output logic borrow_o
);
  logic [W:0] full;

  if (W < 2) begin : g_bad_w
    $error("tje_arith: width too small");
  end

  always_comb begin
    if (sub_i) begin
      full = {1'b0, a_i} - {1'b0, b_i};
    end else begin
      full = {1'b0, a_i} + {1'b0, b_i};
    end
  end

  assign sum_o = full[W-1:0];
  // on subtract the top bit is the borrow, on add the carry
  assign borrow_o = full[W];
endmodule
`default_nettype wire

//--- rtl/tje_exec.sv
// transmit and jump execution: accumulator, Q and program address counter
// assumes one instruction is offered at a time and storage answers each request
//
// Operation
// - Add-and-store adds the double-length operand at u into A, then stores A right half at v unless v is A.
// - Subtract-and-store subtracts the double-length operand at u from A, then stores A right half at v unless v is A.
// - Return jump writes the instruction address plus one into the low 15 bits of u, keeps the rest, and loads v into the counter.
// - Index jump puts the operand at u minus one in A; on a clear sign it writes A right half to u and jumps to v, else continues.
// - Single threshold jump subtracts u from A, jumps to v on a set sign, else continues, and leaves A as it was.
// - Repeated threshold jump loads Q with the repeat state and jumps on a set sign, otherwise advances and tests the count.
// - Single equality jump jumps to v only on a zero difference, found by an end borrow after subtracting one, and keeps A.
// - Repeated equality jump on zero loads Q with the complemented counter and jumps; otherwise advances until the count runs out.
// - Q-jump takes u when the top bit of Q is one and v when zero, then rotates Q left one place.
// - Manual jump goes to v when the selector is 0, and for 1 to 3 only when the matching switch is set.
// - Sign jump loads u into the counter when the accumulator sign bit is one and v when it is zero.
// - Fetching through Q advances the counter and stops when it passes the last Q address into A.
`timescale 1ns/1ps
`default_nettype none
`include "tje_regs.svh"
module tje_exec
  import tje_pkg::*;
#(
  parameter int REP_W = 15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // instruction offer
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire logic [5:0] opcode_i,
  input wire logic repeated_i,
  input wire logic [14:0] u_i,
  input wire logic [14:0] v_i,
  input wire logic [14:0] current_instruction_i,
  input wire logic [2:0] operator_jump_switch_i,
  output logic done_o,
  output logic rep_exhausted_o,
  // register loads from the rest of the machine
  input wire logic acc_load_i,
  input wire logic [71:0] acc_data_i,
  input wire logic q_load_i,
  input wire logic [35:0] q_data_i,
  input wire logic pak_load_i,
  input wire logic [14:0] pak_data_i,
  input wire logic next_instruction_adv_i,
  // machine state
  output logic [71:0] acc_o,
  output logic [35:0] q_o,
  output logic [14:0] program_address_counter_o,
  output logic halt_o,
  // storage pins
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [14:0] mem_addr_o,
  output logic [35:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [35:0] mem_rdata_i
);
  tje_core_type r;
  tje_core_type n;
  tje_mem_if mem_ch ();

  logic [71:0] dx;
  logic [71:0] ar_a;
  logic [71:0] ar_b;
  logic ar_sub;
  logic [71:0] ar_sum;
  logic zero_borrow;
  logic [14:0] seq_addr;
  logic [14:0] pak_adv;
  logic [REP_W-1:0] rep_ones;
  tje_op_type dec_op;

  // repeat count lives in the low bits of the counter, so it cannot be wider
  if (REP_W < 1 || REP_W > 15) begin : g_bad_rep_w
    $error("tje_exec: REP_W must be 1 to 15");
  end

  function automatic logic in_q(input logic [14:0] a);
    in_q = (a >= `TJE_Q_BASE) && (a <= `TJE_Q_LAST);
  endfunction

  function automatic logic in_a(input logic [14:0] a);
    in_a = (a >= `TJE_A_BASE) && (a <= `TJE_A_LAST);
  endfunction

  always_comb begin
    case (opcode_i)
      `TJE_OPC_ADD_STORE: dec_op = TJE_OP_ADD_STORE;
      `TJE_OPC_SUB_STORE: dec_op = TJE_OP_SUB_STORE;
      `TJE_OPC_RETURN: dec_op = TJE_OP_RETURN;
      `TJE_OPC_INDEX: dec_op = TJE_OP_INDEX;
      `TJE_OPC_THRESH: dec_op = TJE_OP_THRESH;
      `TJE_OPC_EQUAL: dec_op = TJE_OP_EQUAL;
      `TJE_OPC_QJUMP: dec_op = TJE_OP_QJUMP;
      `TJE_OPC_MANUAL: dec_op = TJE_OP_MANUAL;
      `TJE_OPC_SIGN: dec_op = TJE_OP_SIGN;
      default: dec_op = TJE_OP_NONE;
    endcase
  end

  // double-length operand: right half sign-extended
  assign dx = {{36{r.x[35]}}, r.x};

  // main adder: A plus or minus D(X), or the index decrement
  always_comb begin
    ar_a = r.acc;
    ar_b = dx;
    ar_sub = 1'b1;
    case (r.op)
      TJE_OP_ADD_STORE: ar_sub = 1'b0;
      TJE_OP_INDEX: begin
        // u naming A means A itself is the operand, kept whole, so only the decrement applies
        ar_a = r.u_is_a ? r.acc : dx;
        ar_b = 72'h1;
      end
      default: ar_sub = 1'b1;
    endcase
  end

  tje_arith #(
    .W(72)
  ) u_main (
    .a_i(ar_a),
    .b_i(ar_b),
    .sub_i(ar_sub),
    .sum_o(ar_sum),
    .borrow_o()
  );

  // zero test: a difference of zero is the only one that borrows out of bit 71
  tje_arith #(
    .W(72)
  ) u_zero (
    .a_i(ar_sum),
    .b_i(72'h1),
    .sub_i(1'b1),
    .sum_o(),
    .borrow_o(zero_borrow)
  );

  tje_mem_port u_port (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ch(mem_ch.port),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );

  assign seq_addr = 15'(r.y + 15'h1);
  assign pak_adv = 15'(r.program_address_counter + 15'h1);
  assign rep_ones = '1;

  always_comb begin
    n = r;
    n.go = 1'b0;
    n.done = 1'b0;
    n.rep_end = 1'b0;
    case (r.st)
      TJE_S_IDLE: begin
        if (acc_load_i) begin
          n.acc = acc_data_i;
        end
        if (q_load_i) begin
          n.q = q_data_i;
        end
        if (pak_load_i) begin
          n.program_address_counter = pak_data_i;
        end else if (next_instruction_adv_i) begin
          n.program_address_counter = pak_adv;
          // running on through Q must stop at the first A address
          if (pak_adv == `TJE_A_BASE) begin
            n.halt = 1'b1;
            n.st = TJE_S_HALT;
          end
        end
        if (instr_valid_i && !n.halt) begin
          n.op = dec_op;
          n.rep = repeated_i;
          n.u = u_i;
          n.v = v_i;
          n.y = current_instruction_i;
          n.u_is_a = in_a(u_i);
          n.st = TJE_S_FETCH;
        end
      end
      TJE_S_FETCH: begin
        n.st = TJE_S_EXEC;
        case (r.op)
          TJE_OP_QJUMP, TJE_OP_MANUAL, TJE_OP_SIGN, TJE_OP_NONE: n.st = TJE_S_EXEC;
          default: begin
            if (in_q(r.u)) begin
              n.x = r.q;
            end else if (r.u_is_a) begin
              n.x = r.acc[35:0];
            end else begin
              n.go = 1'b1;
              n.we = 1'b0;
              n.wa = r.u;
              n.st = TJE_S_WAIT;
            end
          end
        endcase
      end
      TJE_S_WAIT: begin
        if (mem_ch.ack) begin
          n.x = mem_ch.rdata;
          n.st = TJE_S_EXEC;
        end
      end
      TJE_S_EXEC: begin
        n.st = TJE_S_IDLE;
        n.done = 1'b1;
        n.wa = r.v;
        n.wd = ar_sum[35:0];
        case (r.op)
          TJE_OP_ADD_STORE, TJE_OP_SUB_STORE: begin
            n.acc = ar_sum;
            n.done = 1'b0;
            n.st = TJE_S_WRITE;
          end
          TJE_OP_RETURN: begin
            n.wa = r.u;
            n.wd = {r.x[35:`TJE_LINK_W], seq_addr};
            n.program_address_counter = r.v;
            n.done = 1'b0;
            n.st = TJE_S_WRITE;
          end
          TJE_OP_INDEX: begin
            n.acc = ar_sum;
            if (ar_sum[`TJE_SIGN_BIT]) begin
              n.program_address_counter = seq_addr;
            end else begin
              n.program_address_counter = r.v;
              n.wa = r.u;
              n.done = 1'b0;
              n.st = TJE_S_WRITE;
            end
          end
          TJE_OP_THRESH, TJE_OP_EQUAL: begin
            // A is never written here, which is the restore
            if ((r.op == TJE_OP_THRESH) ? ar_sum[`TJE_SIGN_BIT] : zero_borrow) begin
              if (r.rep) begin
                n.q = {21'h0, ~r.program_address_counter};
              end
              n.program_address_counter = r.v;
            end else if (!r.rep) begin
              n.program_address_counter = seq_addr;
            end else if (pak_adv[REP_W-1:0] == rep_ones) begin
              n.program_address_counter = seq_addr;
              n.rep_end = 1'b1;
            end else begin
              n.program_address_counter = pak_adv;
              n.done = 1'b0;
              n.st = TJE_S_FETCH;
            end
          end
          TJE_OP_QJUMP: begin
            n.program_address_counter = r.q[`TJE_Q_TOP] ? r.u : r.v;
            n.q = {r.q[34:0], r.q[`TJE_Q_TOP]};
          end
          TJE_OP_MANUAL: begin
            // selector travels in the low bits of the u field
            if (r.u[1:0] == 2'h0 || operator_jump_switch_i[2'(r.u[1:0] - 2'h1)]) begin
              n.program_address_counter = r.v;
            end else begin
              n.program_address_counter = seq_addr;
            end
          end
          TJE_OP_SIGN: begin
            n.program_address_counter = r.acc[`TJE_SIGN_BIT] ? r.u : r.v;
          end
          default: n.program_address_counter = seq_addr;
        endcase
        if (n.st == TJE_S_WRITE) begin
          // A as destination is dropped, Q as destination stays local
          if (in_a(n.wa)) begin
            n.st = TJE_S_IDLE;
            n.done = 1'b1;
          end else if (in_q(n.wa)) begin
            n.q = n.wd;
            n.st = TJE_S_IDLE;
            n.done = 1'b1;
          end else begin
            n.go = 1'b1;
            n.we = 1'b1;
          end
        end
      end
      TJE_S_WRITE: begin
        if (mem_ch.ack) begin
          n.st = TJE_S_IDLE;
          n.done = 1'b1;
        end
      end
      TJE_S_HALT: n.st = TJE_S_HALT;
      default: n.st = TJE_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign mem_ch.go = r.go;
  assign mem_ch.we = r.we;
  assign mem_ch.addr = r.wa;
  assign mem_ch.wdata = r.wd;

  assign instr_ready_o = (r.st == TJE_S_IDLE) && !r.halt;
  assign done_o = r.done;
  assign rep_exhausted_o = r.rep_end;
  assign acc_o = r.acc;
  assign q_o = r.q;
  assign program_address_counter_o = r.program_address_counter;
  assign halt_o = r.halt;
endmodule
`default_nettype wire

//--- rtl/tje_mem_if.sv
// storage request channel between the executor and its storage port
// one-cycle go from the controller, one-cycle ack back
`timescale 1ns/1ps
`default_nettype none
interface tje_mem_if;
  logic go;
  logic we;
  logic [14:0] addr;
  logic [35:0] wdata;
  logic ack;
  logic [35:0] rdata;

  modport ctrl (output go, output we, output addr, output wdata, input ack, input rdata);
  modport port (input go, input we, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

//--- rtl/tje_mem_port.sv
// storage port: turns one-cycle requests into a held request on the pins
// assumes the store raises mem_ack_i once per request, read data valid with it
`timescale 1ns/1ps
`default_nettype none
module tje_mem_port
  import tje_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // controller side
  tje_mem_if.port ch,
  // storage pins
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [14:0] mem_addr_o,
  output logic [35:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [35:0] mem_rdata_i
);
  tje_port_type r;
  tje_port_type n;

  always_comb begin
    n = r;
    n.ack = 1'b0;
    if (!r.busy && ch.go) begin
      n.busy = 1'b1;
      n.req = 1'b1;
      n.we = ch.we;
      n.addr = ch.addr;
      n.wdata = ch.wdata;
    end else if (r.busy && mem_ack_i) begin
      n.busy = 1'b0;
      n.req = 1'b0;
      n.ack = 1'b1;
      n.rdata = mem_rdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign mem_req_o = r.req;
  assign mem_we_o = r.we;
  assign mem_addr_o = r.addr;
  assign mem_wdata_o = r.wdata;
  assign ch.ack = r.ack;
  assign ch.rdata = r.rdata;
endmodule
`default_nettype wire

//--- rtl/tje_pkg.sv
// types for the transmit and jump execution block
// assumes tje_regs.svh sits beside it
`include "tje_regs.svh"
package tje_pkg;

  typedef enum logic [3:0] {
    TJE_OP_NONE,
    TJE_OP_ADD_STORE,
    TJE_OP_SUB_STORE,
    TJE_OP_RETURN,
    TJE_OP_INDEX,
    TJE_OP_THRESH,
    TJE_OP_EQUAL,
    TJE_OP_QJUMP,
    TJE_OP_MANUAL,
    TJE_OP_SIGN
  } tje_op_type;

  typedef enum logic [2:0] {
    TJE_S_IDLE,
    TJE_S_FETCH,
    TJE_S_WAIT,
    TJE_S_EXEC,
    TJE_S_WRITE,
    TJE_S_HALT
  } tje_state_type;

  typedef struct packed {
    tje_state_type st;
    tje_op_type op;
    logic rep;
    logic u_is_a;
    logic [14:0] u;
    logic [14:0] v;
    logic [14:0] y;
    logic [71:0] acc;
    logic [35:0] q;
    logic [14:0] program_address_counter;
    logic [35:0] x;
    logic go;
    logic we;
    logic [14:0] wa;
    logic [35:0] wd;
    logic done;
    logic rep_end;
    logic halt;
  } tje_core_type;

  typedef struct packed {
    logic busy;
    logic req;
    logic we;
    logic [14:0] addr;
    logic [35:0] wdata;
    logic ack;
    logic [35:0] rdata;
  } tje_port_type;

endpackage

//--- rtl/tje_regs.svh
// constants for the transmit and jump execution block
// included by the package, by tje_exec and by the sim files
`ifndef TJE_REGS_SVH
`define TJE_REGS_SVH

// storage map: Q occupies one window, A the next one up
`define TJE_Q_BASE 15'h3200
`define TJE_Q_LAST 15'h33ff
`define TJE_A_BASE 15'h3400
`define TJE_A_LAST 15'h35ff

// accumulator and Q field positions
`define TJE_SIGN_BIT 71
`define TJE_Q_TOP 35
`define TJE_LINK_W 15

// operation codes
`define TJE_OPC_ADD_STORE 6'h3c
`define TJE_OPC_SUB_STORE 6'h3d
`define TJE_OPC_RETURN 6'h3e
`define TJE_OPC_INDEX 6'h21
`define TJE_OPC_THRESH 6'h22
`define TJE_OPC_EQUAL 6'h23
`define TJE_OPC_QJUMP 6'h24
`define TJE_OPC_MANUAL 6'h25
`define TJE_OPC_SIGN 6'h26

`endif

//--- sim/tje_exec_asserts.sv
// concurrent checks on the ports of tje_exec
// assumes one clock domain; bound to every tje_exec at the foot
`timescale 1ns/1ps
`default_nettype none
`include "tje_regs.svh"
module tje_exec_asserts #(
  parameter int REP_W = 15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // instruction offer
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire logic [5:0] opcode_i,
  input wire logic repeated_i,
  input wire logic [14:0] u_i,
  input wire logic [14:0] v_i,
  input wire logic [14:0] current_instruction_i,
  input wire logic [2:0] operator_jump_switch_i,
  input wire logic done_o,
  // register loads and machine state
  input wire logic pak_load_i,
  input wire logic next_instruction_adv_i,
  input wire logic [71:0] acc_o,
  input wire logic [35:0] q_o,
  input wire logic [14:0] program_address_counter_o,
  input wire logic halt_o,
  // storage pins
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic [35:0] mem_wdata_o
);
  logic [5:0] op_q;
  logic [14:0] u_q, v_q, y1_q;
  logic [71:0] acc_q;
  logic [35:0] qr_q;
  logic [2:0] sw_q;
  wire logic take = instr_valid_i && instr_ready_o;
  wire logic [14:0] program_address_counter = program_address_counter_o;

  // offer fields are only valid at the take edge, so keep them
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {op_q, u_q, v_q, y1_q, acc_q, qr_q, sw_q} <= '0;
    end else if (take) begin
      {op_q, u_q, v_q, acc_q, qr_q, sw_q} <= {opcode_i, u_i, v_i, acc_o, q_o,
          operator_jump_switch_i};
      y1_q <= current_instruction_i + 15'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_sign;
    take && opcode_i == `TJE_OPC_SIGN |-> ##3 (done_o && program_address_counter == (acc_q[71] ? u_q : v_q));
  endproperty
  a_sign: assert property (p_sign) else $error("sign jump target wrong");
  property p_qjump;
    take && opcode_i == `TJE_OPC_QJUMP |-> ##3 (done_o && program_address_counter == (qr_q[35] ? u_q : v_q)
        && q_o == {qr_q[34:0], qr_q[35]});
  endproperty
  a_qjump: assert property (p_qjump) else $error("q jump wrong");
  property p_manual;
    take && opcode_i == `TJE_OPC_MANUAL |-> ##3 (done_o
        && program_address_counter == ((u_q[1:0] == 2'h0 || sw_q[u_q[1:0] - 2'h1]) ? v_q : y1_q));
  endproperty
  a_manual: assert property (p_manual) else $error("manual jump wrong");
  property p_index;
    done_o && op_q == `TJE_OPC_INDEX |-> program_address_counter == (acc_o[71] ? y1_q : v_q);
  endproperty
  a_index: assert property (p_index) else $error("index jump target wrong");
  property p_keep;
    done_o && (op_q == `TJE_OPC_THRESH || op_q == `TJE_OPC_EQUAL) |-> acc_o == acc_q;
  endproperty
  a_keep: assert property (p_keep) else $error("compare jump changed acc");
  property p_store;
    mem_req_o && mem_we_o && (op_q == `TJE_OPC_ADD_STORE || op_q == `TJE_OPC_SUB_STORE)
        |-> mem_addr_o == v_q && mem_wdata_o == acc_o[35:0];
  endproperty
  a_store: assert property (p_store) else $error("transmit store wrong");
  property p_no_a;
    mem_req_o && mem_we_o |-> !(mem_addr_o inside {[`TJE_A_BASE:`TJE_A_LAST]});
  endproperty
  a_no_a: assert property (p_no_a) else $error("store sent to acc window");
  property p_return;
    mem_req_o && mem_we_o && op_q == `TJE_OPC_RETURN |-> mem_addr_o == u_q
        && mem_wdata_o[14:0] == y1_q;
  endproperty
  a_return: assert property (p_return) else $error("return link wrong");
  property p_halt;
    next_instruction_adv_i && instr_ready_o && !pak_load_i && program_address_counter == `TJE_Q_LAST
        |-> ##[1:2] halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt past q window");
  property p_halt_hold;
    halt_o |=> halt_o;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt released");
endmodule

bind tje_exec tje_exec_asserts #(.REP_W(REP_W)) chk_u (.clk_i, .sys_rst_i, .instr_valid_i,
    .instr_ready_o, .opcode_i, .repeated_i, .u_i, .v_i, .current_instruction_i,
    .operator_jump_switch_i, .done_o, .pak_load_i, .next_instruction_adv_i, .acc_o, .q_o,
    .program_address_counter_o, .halt_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o);
`default_nettype wire

//--- sim/transmit_and_jump_execution_bench.sv
// self-checking bench for tje_exec
// the bench plays the store and the rest of the machine at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "tje_regs.svh"
module transmit_and_jump_execution_bench;
  localparam logic [14:0] Y = 15'h0100;
  localparam logic [14:0] U = 15'h0010;
  localparam logic [14:0] V = 15'h0200;
  localparam logic [14:0] W = 15'h0020;
  logic clk_i, sys_rst_i, instr_valid_i, repeated_i, acc_load_i, q_load_i, pak_load_i;
  logic next_instruction_adv_i, mem_ack_i, cool, rx;
  logic [5:0] opcode_i;
  logic [14:0] u_i, v_i, current_instruction_i, pak_data_i;
  logic [2:0] operator_jump_switch_i;
  logic [71:0] acc_data_i;
  logic [35:0] q_data_i, mem_rdata_i;
  logic [35:0] mem [int];
  wire logic instr_ready_o, done_o, rep_exhausted_o, halt_o, mem_req_o, mem_we_o;
  wire logic [14:0] program_address_counter_o, mem_addr_o;
  wire logic [71:0] acc_o;
  wire logic [35:0] q_o, mem_wdata_o;
  int errors, checks_done, wr_n;

  tje_exec #(.REP_W(15)) dut_u (.clk_i, .sys_rst_i, .instr_valid_i, .instr_ready_o,
      .opcode_i, .repeated_i, .u_i, .v_i, .current_instruction_i, .operator_jump_switch_i,
      .done_o, .rep_exhausted_o, .acc_load_i, .acc_data_i, .q_load_i, .q_data_i, .pak_load_i,
      .pak_data_i, .next_instruction_adv_i, .acc_o, .q_o, .program_address_counter_o,
      .halt_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i);

  always #2.5 clk_i = ~clk_i;

  // store: ack one cycle after req, then skip a cycle while req falls
  always @(negedge clk_i) begin
    if (mem_ack_i) begin
      mem_ack_i = 1'b0;
      mem_rdata_i = ~mem_rdata_i;
      cool = 1'b1;
    end else if (cool) begin
      cool = 1'b0;
    end else if (mem_req_o === 1'b1) begin
      mem_ack_i = 1'b1;
      if (mem_we_o) begin
        mem[mem_addr_o] = mem_wdata_o;
        wr_n++;
      end else begin
        mem_rdata_i = mem.exists(mem_addr_o) ? mem[mem_addr_o] : 36'h0;
      end
    end
  end

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ld(input logic [71:0] a, input logic [35:0] q, input logic [14:0] p);
    @(negedge clk_i);
    {acc_load_i, q_load_i, pak_load_i} = 3'b111;
    {acc_data_i, q_data_i, pak_data_i} = {a, q, p};
    @(negedge clk_i);
    {acc_load_i, q_load_i, pak_load_i} = 3'b000;
  endtask

  task automatic ex(input logic [5:0] op, input logic rep, input logic [14:0] u,
      input logic [14:0] v);
    int n;
    @(negedge clk_i);
    {instr_valid_i, opcode_i, repeated_i, u_i, v_i} = {1'b1, op, rep, u, v};
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk(done_o, 72'h1);
    rx = rep_exhausted_o;
  endtask

  task automatic t_jumps;
    logic [2:0] sw;
    chk(instr_ready_o, 72'h1);
    chk(program_address_counter_o, 72'h0);
    ld({1'b1, 71'h5}, 36'h8_0000_0001, 15'h0);
    ex(`TJE_OPC_SIGN, 1'b0, U, V);
    chk(program_address_counter_o, U);
    ex(`TJE_OPC_QJUMP, 1'b0, U, V);
    chk(program_address_counter_o, U);
    chk(q_o, 36'h0_0000_0003);
    ex(`TJE_OPC_QJUMP, 1'b0, U, V);
    chk(program_address_counter_o, V);
    ld(72'h5, 36'h0, 15'h0);
    ex(`TJE_OPC_SIGN, 1'b0, U, V);
    chk(program_address_counter_o, V);
    for (int s = 0; s < 2; s++) begin
      sw = s ? 3'b101 : 3'b010;
      operator_jump_switch_i = sw;
      for (int j = 0; j < 4; j++) begin
        ex(`TJE_OPC_MANUAL, 1'b0, 15'(j), V);
        chk(program_address_counter_o, (j == 0 || sw[j-1]) ? V : Y + 15'h1);
      end
    end
    $display("test jumps done");
  endtask

  task automatic t_transmit;
    int n;
    mem[U] = 36'hf_ffff_fffd;
    ld(72'h01_0000_0000_0000_0005, 36'h0, 15'h0);
    ex(`TJE_OPC_ADD_STORE, 1'b0, U, W);
    chk(acc_o, 72'h01_0000_0000_0000_0002);
    chk(mem[W], 36'h2);
    n = wr_n;
    ex(`TJE_OPC_SUB_STORE, 1'b0, U, `TJE_A_BASE);
    chk(acc_o, 72'h01_0000_0000_0000_0005);
    chk(wr_n, n);
    mem[U] = 36'hf_ffff_ffff;
    ex(`TJE_OPC_RETURN, 1'b0, U, V);
    chk(mem[U], 36'hf_ffff_8101);
    chk(program_address_counter_o, V);
    mem[U] = 36'h5;
    ex(`TJE_OPC_INDEX, 1'b0, U, V);
    chk(acc_o, 72'h4);
    chk(mem[U], 36'h4);
    chk(program_address_counter_o, V);
    mem[U] = 36'h0;
    ex(`TJE_OPC_INDEX, 1'b0, U, V);
    chk(acc_o, {72{1'b1}});
    chk(mem[U], 36'h0);
    chk(program_address_counter_o, Y + 15'h1);
    // local operands: Q as source and destination, A as index operand
    ld(72'h1, 36'h2, 15'h0);
    ex(`TJE_OPC_ADD_STORE, 1'b0, `TJE_Q_BASE, `TJE_Q_BASE);
    chk(acc_o, 72'h3);
    chk(q_o, 36'h3);
    ld(72'h5, 36'h0, 15'h0);
    ex(`TJE_OPC_INDEX, 1'b0, `TJE_A_BASE, V);
    chk(acc_o, 72'h4);
    chk(program_address_counter_o, V);
    $display("test transmit done");
  endtask

  task automatic t_compare;
    ld(72'h3, 36'h0, 15'h0);
    for (int k = 2; k < 6; k++) begin
      mem[U] = 36'(k);
      ex(`TJE_OPC_THRESH, 1'b0, U, V);
      chk(program_address_counter_o, (k > 3) ? V : Y + 15'h1);
      chk(acc_o, 72'h3);
      ex(`TJE_OPC_EQUAL, 1'b0, U, V);
      chk(program_address_counter_o, (k == 3) ? V : Y + 15'h1);
      chk(acc_o, 72'h3);
    end
    // counter preloaded as the repeat instruction would leave it
    for (int i = 0; i < 2; i++) begin
      ld(72'h0, 36'h0, 15'h7ff0);
      mem[U] = (i == 0) ? 36'h1 : 36'h0;
      ex(i ? `TJE_OPC_EQUAL : `TJE_OPC_THRESH, 1'b1, U, V);
      chk(q_o, 36'h0_0000_000f);
      chk(program_address_counter_o, V);
      chk(rx, 72'h0);
      ld(72'h0, 36'h0, 15'h7ffd);
      mem[U] = 36'(i);
      ex(i ? `TJE_OPC_EQUAL : `TJE_OPC_THRESH, 1'b1, U, V);
      chk(rx, 72'h1);
      chk(program_address_counter_o, Y + 15'h1);
      chk(acc_o, 72'h0);
    end
    $display("test compare done");
  endtask

  task automatic t_halt;
    ld(72'h0, 36'h0, `TJE_Q_LAST);
    next_instruction_adv_i = 1'b1;
    @(negedge clk_i);
    next_instruction_adv_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(program_address_counter_o, `TJE_A_BASE);
    chk(halt_o, 72'h1);
    chk(instr_ready_o, 72'h0);
    $display("test halt done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    {clk_i, sys_rst_i, instr_valid_i, repeated_i, acc_load_i, q_load_i, pak_load_i} = 7'h20;
    {next_instruction_adv_i, mem_ack_i, cool, opcode_i, u_i, v_i, pak_data_i} = '0;
    {operator_jump_switch_i, acc_data_i, q_data_i, mem_rdata_i} = '0;
    current_instruction_i = Y;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_jumps();
    t_transmit();
    t_compare();
    t_halt();
    results();
  end

  // whole run needs a few hundred cycles
  initial begin
    #100000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
